// ===== src/scm_pkg.sv
package scm_pkg;

	// ------------------------------------------------------------
	// Register map and fields
	// ------------------------------------------------------------
	localparam logic [7:0] SCM_OFS_MODE = 8'h03;
	localparam logic [7:0] SCM_OFS_FMT = 8'h04;
	localparam logic [7:0] SCM_OFS_CLKCFG = 8'h05;
	localparam logic [7:0] SCM_OFS_CLKOUT_M = 8'h06;
	localparam logic [7:0] SCM_OFS_CLKOUT_N = 8'h07;
	localparam logic [7:0] SCM_OFS_PCFG = 8'h10;
	localparam logic [7:0] SCM_OFS_PDT = 8'h11;

	localparam int SCM_MODE_WE_BIT = 4;
	localparam int SCM_OSC_SEL_BIT = 3;
	localparam int SCM_IN_DIV_BIT = 0;
	localparam int SCM_FMT_OVR_BIT = 0;
	localparam int SCM_FMT_RAW12_BIT = 1;
	localparam int SCM_TYPE_MATCH_BIT = 7;

	// ------------------------------------------------------------
	// Mode codes
	// ------------------------------------------------------------
	localparam logic [2:0] SCM_MODE_SYNC = 3'h0;
	localparam logic [2:0] SCM_MODE_EXT = 3'h2;
	localparam logic [2:0] SCM_MODE_INT = 3'h3;
	localparam logic [2:0] SCM_MODE_LEGACY = 3'h5;

	// Forward reference select codes
	localparam logic [1:0] SCM_REF_BACKCH = 2'h0;
	localparam logic [1:0] SCM_REF_EXT = 2'h1;
	localparam logic [1:0] SCM_REF_OSC = 2'h2;

	// ------------------------------------------------------------
	// Ratios
	// ------------------------------------------------------------
	localparam logic [7:0] SCM_FC_SYNC = 8'hA0;
	localparam logic [7:0] SCM_BW_SYNC = 8'h80;
	localparam logic [7:0] SCM_FC_EXT1 = 8'h50;
	localparam logic [7:0] SCM_BW_EXT1 = 8'h40;
	localparam logic [7:0] SCM_FC_EXT2 = 8'h28;
	localparam logic [7:0] SCM_BW_EXT2 = 8'h20;
	localparam logic [7:0] SCM_FC_LEGACY = 8'h1C;
	localparam logic [7:0] SCM_BW_LEGACY = 8'h14;

	// Predivider codes: 0 -> 4, 1 -> 8, 2 -> 16
	localparam logic [1:0] SCM_HSDIV_4 = 2'h0;
	localparam logic [1:0] SCM_HSDIV_8 = 2'h1;
	localparam logic [1:0] SCM_HSDIV_16 = 2'h2;

	// Raw pixel packet types
	localparam logic [5:0] SCM_DT_RAW10 = 6'h2B;
	localparam logic [5:0] SCM_DT_RAW12 = 6'h2C;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] SCM_RST_FMT = 8'h00;
	localparam logic [7:0] SCM_RST_CLKCFG = 8'h00;
	localparam logic [7:0] SCM_RST_CLKOUT_M = 8'h01;
	localparam logic [7:0] SCM_RST_CLKOUT_N = 8'h01;
	localparam logic [7:0] SCM_RST_PCFG = 8'h00;
	localparam logic [7:0] SCM_RST_PDT = 8'h00;

	typedef struct packed {
		logic [2:0] mode;
		logic mode_we;
		logic [7:0] clkcfg;
		logic [7:0] fmt;
		logic [7:0] clkout_m;
		logic [7:0] clkout_n;
		logic [7:0] pcfg;
		logic [7:0] pdt;
		logic pwr_prev;
		logic [2:0] ref_prev;
		logic ref_tick;
		logic [1:0] ref_sel;
		logic [7:0] fc_mult;
		logic [7:0] bw_mult;
		logic clkout_en;
		logic [7:0] rdata;
		logic pkt_pass;
		logic pkt_vld;
	} scm_state_t;

	typedef struct packed {
		logic [15:0] acc;
		logic clk;
	} scm_gen_state_t;

endpackage : scm_pkg

// ===== src/scm_sync.sv
`timescale 1ns/1ps
module scm_sync #(
	parameter int W = 1
) (
	input wire logic clk_sys, // System clock
	input wire logic sys_rst, // Synchronous reset
	input wire logic [W-1:0] d_in, // Asynchronous inputs
	output logic [W-1:0] d_out // Synchronised inputs
);

	logic [W-1:0] meta_q;

	// First stage feeds only the second stage
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			meta_q <= '0;
			d_out <= '0;
		end else begin
			meta_q <= d_in;
			d_out <= meta_q;
		end
	end

endmodule : scm_sync

// ===== src/scm_clkout_gen.sv
`timescale 1ns/1ps
module scm_clkout_gen
	import scm_pkg::*;
(
	input wire logic clk_sys, // System clock
	input wire logic sys_rst, // Synchronous reset
	input wire logic enable, // Sensor clock allowed
	input wire logic ref_tick, // One pulse per reference period
	input wire logic [7:0] fc_mult, // Forward rate per reference period
	input wire logic [4:0] num_m, // Numerator
	input wire logic [7:0] den_n, // Denominator
	input wire logic [4:0] hs_div, // Predivider value
	output logic sensor_clk // Sensor reference clock
);

	scm_gen_state_t s_q, s_d;
	logic [15:0] inc;
	logic [15:0] thr;
	logic [15:0] sum;

	// Each toggle is a half period, so the increment is doubled
	assign inc = 16'(({8'h00, fc_mult} * {11'h000, num_m}) << 1); // [RL10]
	assign thr = 16'({11'h000, hs_div} * {8'h00, den_n}); // [RL10]
	assign sum = s_q.acc + inc;

	// Limitation: at most one toggle per reference tick, so fc_mult*M/(div*N) above 1/2 saturates
	always_comb begin
		s_d = s_q;
		if (!enable) begin
			s_d.acc = '0;
			s_d.clk = 1'b0;
		end else if (ref_tick && thr != 16'h0000) begin
			if (sum >= thr) begin
				// Clip so a ratio above one half cannot wind the accumulator up
				s_d.acc = (sum - thr >= thr) ? thr - 16'h0001 : sum - thr;
				s_d.clk = ~s_q.clk;
			end else begin
				s_d.acc = sum;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign sensor_clk = s_q.clk;

endmodule : scm_clkout_gen

// ===== src/scm_clock_mode_ctrl.sv
// What this block does
// RL1: The clock mode is caught from the strap when the power enable pin rises and used by default.
// RL2: The mode field always shows the active mode and ignores writes while its write-enable bit 4 is 0; the code also takes a write that sets bit 4 itself.
// RL3: With write enable set the mode field takes writes, so software can force the legacy mode with 5.
// RL4: Synchronous mode uses the back-channel clock, forward rate 160x and camera bandwidth 128x.
// RL5: External mode uses the input clock, forward rate 80x with divider 1 or 40x with divider 2.
// RL6: In the non-synchronous modes the sensor keeps its data rate below the forward line rate.
// RL7: Internal mode uses the always-on oscillator as reference with forward rate 80x.
// RL8: In internal mode software sets the oscillator select bit and keeps the sensor clock off.
// RL9: The sensor clock runs only in synchronous and external modes and is off in internal mode; the code also runs it in legacy mode.
// RL10: Sensor clock equals forward rate times M divided by predivider times N; the code caps it at half the reference clock rate.
// RL11: The predivider is programmed to 16, 8 or 4 and resets to 4.
// RL12: Legacy mode runs forward rate 28x with divider 1 and limits camera bandwidth to 20x.
// RL13: In legacy mode the sensor supplies data synchronous to the external reference input.
// RL14: The legacy format override register forces legacy mode to 10-bit or 12-bit raw formatting.
// RL15: With type match enabled, packets of the programmed type pass regardless of the raw setting.
// RL16: Mode codes are 0 synchronous, 2 external, 3 internal and 5 legacy.
// RL17: A mode write switches the reference selection and ratios to those of the new mode.
`timescale 1ns/1ps
module scm_clock_mode_ctrl
	import scm_pkg::*;
(
	input wire logic clk_sys, // System clock, 100 MHz
	input wire logic sys_rst, // Synchronous reset, active high
	input wire logic chip_power_enable, // Power enable pin
	input wire logic [2:0] mode_strap, // Decoded mode strap pins
	input wire logic backch_ref_clk, // Clock recovered from back channel
	input wire logic ext_ref_input, // External reference input pin
	input wire logic always_on_oscillator, // Internal oscillator
	input wire logic [7:0] reg_addr, // Register address
	input wire logic [7:0] reg_wdata, // Register write data
	input wire logic reg_we, // Register write strobe
	input wire logic reg_re, // Register read strobe
	input wire logic pkt_valid, // Packet header valid
	input wire logic [5:0] pkt_dt, // Packet data type
	output logic [7:0] reg_rdata, // Register read data
	output logic [1:0] fwd_ref_sel, // Forward reference source
	output logic [7:0] fwd_rate_mult, // Forward rate over reference
	output logic [7:0] csi_bw_mult, // Camera bandwidth limit over reference
	output logic sensor_clk_en, // Sensor clock enabled
	output logic sensor_clk_out, // Sensor reference clock
	output logic [2:0] active_mode, // Mode in force
	output logic input_ref_divider, // 1 selects divide by two
	output logic internal_osc_rate_select, // Oscillator fast select
	output logic legacy_fmt_forced, // Legacy format forced
	output logic legacy_fmt_raw12, // Forced format is 12-bit
	output logic type_match_enable, // Type match enable
	output logic [7:0] parallel_cfg, // Legacy data config
	output logic pkt_pass, // Packet passes legacy filter
	output logic pkt_pass_vld // Filter answer valid
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic legal_mode(input logic [2:0] m);
		legal_mode = (m == SCM_MODE_SYNC) || (m == SCM_MODE_EXT) ||
			(m == SCM_MODE_INT) || (m == SCM_MODE_LEGACY); // [RL16]
	endfunction : legal_mode

	function automatic logic [4:0] hsdiv_value(input logic [1:0] code);
		case (code)
			SCM_HSDIV_8: hsdiv_value = 5'd8;
			SCM_HSDIV_16: hsdiv_value = 5'd16;
			default: hsdiv_value = 5'd4; // [RL11]
		endcase
	endfunction : hsdiv_value

	// Write strobe decode, one hit per register offset
	function automatic logic wr_hit(input logic we, input logic [7:0] addr, input logic [7:0] ofs);
		wr_hit = we && addr == ofs;
	endfunction : wr_hit

	// External input ratios depend on the input divider
	function automatic logic [7:0] div_pick(input logic div2, input logic [7:0] by1, input logic [7:0] by2);
		div_pick = div2 ? by2 : by1;
	endfunction : div_pick

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [6:0] pins_s;
	logic pwr_s;
	logic [2:0] strap_s;
	logic [2:0] ref_s;

	scm_sync #(
		.W(7)
	) u_sync (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.d_in({chip_power_enable, mode_strap, always_on_oscillator, ext_ref_input, backch_ref_clk}),
		.d_out(pins_s)
	);

	assign pwr_s = pins_s[6];
	assign strap_s = pins_s[5:3];
	assign ref_s = pins_s[2:0];

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	scm_state_t s_q, s_d;
	logic wr_mode;
	logic wr_fmt;
	logic wr_clkcfg;
	logic wr_m;
	logic wr_n;
	logic wr_pcfg;
	logic wr_pdt;
	logic [2:0] ref_rise;
	logic [2:0] next_mode;
	logic [1:0] next_hs;
	logic [5:0] raw_dt;

	// ------------------------------------------------------------
	// Register write decode
	// ------------------------------------------------------------
	assign wr_mode = wr_hit(reg_we, reg_addr, SCM_OFS_MODE);
	assign wr_fmt = wr_hit(reg_we, reg_addr, SCM_OFS_FMT);
	assign wr_clkcfg = wr_hit(reg_we, reg_addr, SCM_OFS_CLKCFG);
	assign wr_m = wr_hit(reg_we, reg_addr, SCM_OFS_CLKOUT_M);
	assign wr_n = wr_hit(reg_we, reg_addr, SCM_OFS_CLKOUT_N);
	assign wr_pcfg = wr_hit(reg_we, reg_addr, SCM_OFS_PCFG);
	assign wr_pdt = wr_hit(reg_we, reg_addr, SCM_OFS_PDT);

	// ------------------------------------------------------------
	// Reference edges and expected raw type
	// ------------------------------------------------------------
	assign ref_rise = ref_s & ~s_q.ref_prev;
	assign next_hs = reg_wdata[6:5];
	assign raw_dt = s_q.fmt[SCM_FMT_RAW12_BIT] ? SCM_DT_RAW12 : SCM_DT_RAW10;

	always_comb begin
		s_d = s_q;
		next_mode = s_q.mode;
		s_d.pwr_prev = pwr_s;
		s_d.ref_prev = ref_s;

		// --------------------------------------------------------
		// Mode field
		// --------------------------------------------------------
		if (wr_mode) begin
			// A refused write still updates the stored write enable
			s_d.mode_we = reg_wdata[SCM_MODE_WE_BIT];
			// Write enable may be set by the same write that carries the mode
			if ((s_q.mode_we || reg_wdata[SCM_MODE_WE_BIT]) && legal_mode(reg_wdata[2:0])) begin
				next_mode = reg_wdata[2:0]; // [RL2] [RL3]
			end
		end
		// Strap capture on power-up outranks a racing register write
		// Unknown strap codes are kept so the fault shows on active_mode
		if (pwr_s && !s_q.pwr_prev) begin
			next_mode = strap_s; // [RL1]
		end
		s_d.mode = next_mode;

		// --------------------------------------------------------
		// Plain registers
		// --------------------------------------------------------
		if (wr_clkcfg) begin
			s_d.clkcfg = reg_wdata & 8'h09;
		end
		if (wr_fmt) begin
			s_d.fmt = reg_wdata & 8'h03; // [RL14]
		end
		// Predivider code 3 is not a legal divider, so such writes keep the old code
		if (wr_m) begin
			s_d.clkout_m = {1'b0, (next_hs == 2'h3) ? s_q.clkout_m[6:5] : next_hs, reg_wdata[4:0]}; // [RL11]
		end
		if (wr_n) begin
			s_d.clkout_n = reg_wdata;
		end
		if (wr_pcfg) begin
			s_d.pcfg = reg_wdata;
		end
		if (wr_pdt) begin
			s_d.pdt = reg_wdata & 8'h3F;
		end

		// --------------------------------------------------------
		// Reference and ratios follow the mode now in force
		// --------------------------------------------------------
		case (s_q.mode)
			SCM_MODE_SYNC: begin
				s_d.ref_sel = SCM_REF_BACKCH; // [RL4] [RL17]
				s_d.fc_mult = SCM_FC_SYNC;
				s_d.bw_mult = SCM_BW_SYNC;
				s_d.clkout_en = 1'b1; // [RL9]
			end
			SCM_MODE_EXT: begin
				s_d.ref_sel = SCM_REF_EXT; // [RL5] [RL17]
				s_d.fc_mult = div_pick(s_q.clkcfg[SCM_IN_DIV_BIT], SCM_FC_EXT1, SCM_FC_EXT2);
				s_d.bw_mult = div_pick(s_q.clkcfg[SCM_IN_DIV_BIT], SCM_BW_EXT1, SCM_BW_EXT2);
				s_d.clkout_en = 1'b1; // [RL9]
			end
			SCM_MODE_INT: begin
				s_d.ref_sel = SCM_REF_OSC; // [RL7] [RL17]
				s_d.fc_mult = SCM_FC_EXT1;
				s_d.bw_mult = SCM_BW_EXT1;
				s_d.clkout_en = 1'b0; // [RL9]
			end
			SCM_MODE_LEGACY: begin
				// Input divider is not offered here; the ratio assumes divide by one
				s_d.ref_sel = SCM_REF_EXT; // [RL12] [RL17]
				s_d.fc_mult = SCM_FC_LEGACY;
				s_d.bw_mult = SCM_BW_LEGACY;
				s_d.clkout_en = 1'b1;
			end
			default: begin
				// Unknown strap: hold the link off rather than guess a reference
				s_d.ref_sel = SCM_REF_BACKCH;
				s_d.fc_mult = 8'h00;
				s_d.bw_mult = 8'h00;
				s_d.clkout_en = 1'b0;
			end
		endcase
		s_d.ref_tick = ref_rise[s_q.ref_sel];

		// --------------------------------------------------------
		// Legacy packet type filter
		// --------------------------------------------------------
		// One answer per header, headers are not buffered
		s_d.pkt_vld = pkt_valid;
		s_d.pkt_pass = 1'b0;
		if (pkt_valid) begin
			s_d.pkt_pass = (s_q.pcfg[SCM_TYPE_MATCH_BIT] && pkt_dt == s_q.pdt[5:0]) || // [RL15]
				(pkt_dt == raw_dt); // [RL14]
		end

		// --------------------------------------------------------
		// Read data
		// --------------------------------------------------------
		// Read data holds between reads so a slow poll sees a stable value
		if (reg_re) begin
			case (reg_addr)
				SCM_OFS_MODE: s_d.rdata = {3'h0, s_q.mode_we, 1'b0, s_q.mode}; // [RL2]
				SCM_OFS_FMT: s_d.rdata = s_q.fmt;
				SCM_OFS_CLKCFG: s_d.rdata = s_q.clkcfg;
				SCM_OFS_CLKOUT_M: s_d.rdata = s_q.clkout_m;
				SCM_OFS_CLKOUT_N: s_d.rdata = s_q.clkout_n;
				SCM_OFS_PCFG: s_d.rdata = s_q.pcfg;
				SCM_OFS_PDT: s_d.rdata = s_q.pdt;
				default: s_d.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			// Clear everything, then load the register reset values
			s_q <= '0;
			s_q.fmt <= SCM_RST_FMT;
			s_q.clkcfg <= SCM_RST_CLKCFG;
			s_q.clkout_m <= SCM_RST_CLKOUT_M; // [RL11]
			s_q.clkout_n <= SCM_RST_CLKOUT_N;
			s_q.pcfg <= SCM_RST_PCFG;
			s_q.pdt <= SCM_RST_PDT;
			s_q.mode <= SCM_MODE_SYNC;
		end else begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------
	// Sensor clock generator
	// ------------------------------------------------------------
	// Reference inputs are sampled, so they must stay below half of clk_sys
	scm_clkout_gen u_clkout (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.enable(s_q.clkout_en),
		.ref_tick(s_q.ref_tick),
		.fc_mult(s_q.fc_mult),
		.num_m(s_q.clkout_m[4:0]),
		.den_n(s_q.clkout_n),
		.hs_div(hsdiv_value(s_q.clkout_m[6:5])),
		.sensor_clk(sensor_clk_out)
	);

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign reg_rdata = s_q.rdata;
	assign fwd_ref_sel = s_q.ref_sel;
	assign fwd_rate_mult = s_q.fc_mult;
	assign csi_bw_mult = s_q.bw_mult;
	assign sensor_clk_en = s_q.clkout_en;
	assign active_mode = s_q.mode;

	// ------------------------------------------------------------
	// Register fields seen as pins
	// ------------------------------------------------------------
	assign input_ref_divider = s_q.clkcfg[SCM_IN_DIV_BIT];
	assign internal_osc_rate_select = s_q.clkcfg[SCM_OSC_SEL_BIT];
	assign legacy_fmt_forced = s_q.fmt[SCM_FMT_OVR_BIT];
	assign legacy_fmt_raw12 = s_q.fmt[SCM_FMT_RAW12_BIT];
	assign type_match_enable = s_q.pcfg[SCM_TYPE_MATCH_BIT];
	assign parallel_cfg = s_q.pcfg;
	assign pkt_pass = s_q.pkt_pass;
	assign pkt_pass_vld = s_q.pkt_vld;

endmodule : scm_clock_mode_ctrl

// ===== sim/scm_ref_src.sv
`timescale 1ns/1ps
module scm_ref_src (
	output logic backch_ref_clk, // Recovered back channel clock
	output logic ext_ref_input, // External reference
	output logic always_on_oscillator // Internal oscillator
);
	// ------------------------------------------------------------
	// Free running references, every edge 2 ns ahead of a clk_sys rising edge
	// ------------------------------------------------------------
	initial begin
		backch_ref_clk = 1'b0;
		ext_ref_input = 1'b0;
		always_on_oscillator = 1'b0;
		#3;
		fork
			forever #40 backch_ref_clk = ~backch_ref_clk;
			forever #30 ext_ref_input = ~ext_ref_input;
			forever #50 always_on_oscillator = ~always_on_oscillator;
		join
	end
endmodule : scm_ref_src

// ===== sim/scm_clock_mode_ctrl_asserts.sv
`timescale 1ns/1ps
module scm_clock_mode_ctrl_asserts
	import scm_pkg::*;
(
	input wire logic clk_sys, // Clock
	input wire logic sys_rst, // Reset
	input wire logic chip_power_enable, // Power pin
	input wire logic [2:0] mode_strap, // Strap code
	input wire logic reg_re, // Read strobe
	input wire logic pkt_valid, // Packet valid
	input wire logic [5:0] pkt_dt, // Packet type
	input wire logic [7:0] reg_rdata, // Read data
	input wire logic [1:0] fwd_ref_sel, // Reference
	input wire logic [7:0] fwd_rate_mult, // Forward ratio
	input wire logic [7:0] csi_bw_mult, // Bandwidth ratio
	input wire logic sensor_clk_en, // Sensor clock enable
	input wire logic sensor_clk_out, // Sensor clock
	input wire logic [2:0] active_mode, // Mode in force
	input wire logic input_ref_divider, // Divide by two
	input wire logic legacy_fmt_raw12, // 12-bit format
	input wire logic pkt_pass, // Filter result
	input wire logic pkt_pass_vld // Filter valid
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	property p_strap;
		$rose(chip_power_enable) |-> ##[2:5] active_mode == mode_strap;
	endproperty
	a_strap: assert property (p_strap) else $error("strap mode not taken");
	property p_sync;
		!$past(sys_rst) && active_mode == SCM_MODE_SYNC |=> fwd_ref_sel == SCM_REF_BACKCH
			&& fwd_rate_mult == SCM_FC_SYNC && csi_bw_mult == SCM_BW_SYNC && sensor_clk_en;
	endproperty
	a_sync: assert property (p_sync) else $error("sync ratios wrong");
	property p_ext;
		active_mode == SCM_MODE_EXT |=> fwd_ref_sel == SCM_REF_EXT && sensor_clk_en
			&& fwd_rate_mult == ($past(input_ref_divider) ? SCM_FC_EXT2 : SCM_FC_EXT1)
			&& csi_bw_mult == ($past(input_ref_divider) ? SCM_BW_EXT2 : SCM_BW_EXT1);
	endproperty
	a_ext: assert property (p_ext) else $error("external ratios wrong");
	property p_int;
		active_mode == SCM_MODE_INT |=> fwd_ref_sel == SCM_REF_OSC && fwd_rate_mult == SCM_FC_EXT1 && !sensor_clk_en;
	endproperty
	a_int: assert property (p_int) else $error("internal mode wrong");
	property p_legacy;
		active_mode == SCM_MODE_LEGACY |=> fwd_ref_sel == SCM_REF_EXT && fwd_rate_mult == SCM_FC_LEGACY
			&& csi_bw_mult == SCM_BW_LEGACY && sensor_clk_en;
	endproperty
	a_legacy: assert property (p_legacy) else $error("legacy ratios wrong");
	property p_sclk_off;
		!sensor_clk_en [*3] |-> !sensor_clk_out;
	endproperty
	a_sclk_off: assert property (p_sclk_off) else $error("sensor clock runs while off");
	property p_pkt;
		pkt_valid |=> pkt_pass_vld;
	endproperty
	a_pkt: assert property (p_pkt) else $error("filter answer missing");
	property p_pass_raw;
		pkt_valid && $stable(legacy_fmt_raw12) && pkt_dt == (legacy_fmt_raw12 ? SCM_DT_RAW12 : SCM_DT_RAW10)
			|=> pkt_pass;
	endproperty
	a_pass_raw: assert property (p_pass_raw) else $error("raw packet dropped");
	property p_rd_hold;
		!reg_re |=> $stable(reg_rdata);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
endmodule : scm_clock_mode_ctrl_asserts

bind scm_clock_mode_ctrl scm_clock_mode_ctrl_asserts u_scm_clock_mode_ctrl_asserts (.*);

// ===== sim/tb_top.sv
`timescale 1ns/1ps
module tb_top
	import scm_pkg::*;
;
	logic clk_sys, sys_rst, chip_power_enable, reg_we, reg_re, pkt_valid;
	logic [2:0] mode_strap, active_mode;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, fwd_rate_mult, csi_bw_mult, parallel_cfg;
	logic [5:0] pkt_dt;
	logic [1:0] fwd_ref_sel;
	logic backch_ref_clk, ext_ref_input, always_on_oscillator, sensor_clk_en, sensor_clk_out;
	logic input_ref_divider, internal_osc_rate_select, legacy_fmt_forced, legacy_fmt_raw12;
	logic type_match_enable, pkt_pass, pkt_pass_vld;
	int mismatches, n_compared, seed;
	int mdl[256];

	scm_clock_mode_ctrl u_scm_clock_mode_ctrl (.*);
	scm_ref_src u_scm_ref_src (.*);

	// ------------------------------------------------------------
	// Bench tasks and reference model
	// ------------------------------------------------------------
	task automatic chk(string n, logic [31:0] s, logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %0h seen %0h", n, e, s);
		end
	endtask : chk
	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : complete_run
	// Mask k of zero leaves the model alone for a write that must be refused
	task automatic wr(logic [7:0] a, logic [7:0] d, logic [7:0] k);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_we <= 1'b1;
		@(posedge clk_sys);
		reg_we <= 1'b0;
		if (k != 8'h00) mdl[a] = d & k;
	endtask : wr
	task automatic rd(logic [7:0] a, logic [7:0] m);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_re <= 1'b1;
		@(posedge clk_sys);
		reg_re <= 1'b0;
		#1 chk("reg_rdata", reg_rdata & m, mdl[a] & m);
	endtask : rd
	function automatic logic [18:0] mexp(int m, int dv);
		case (m)
			0: return {SCM_REF_BACKCH, 8'hA0, 8'h80, 1'b1};
			2: return dv ? {SCM_REF_EXT, 8'h28, 8'h20, 1'b1} : {SCM_REF_EXT, 8'h50, 8'h40, 1'b1};
			3: return {SCM_REF_OSC, 8'h50, 8'h40, 1'b0};
			5: return {SCM_REF_EXT, 8'h1C, 8'h14, 1'b1};
			default: return 19'h0_0000;
		endcase
	endfunction : mexp
	task automatic mchk(int c);
		repeat (2) @(posedge clk_sys);
		#1 chk("active_mode", active_mode, c);
		chk("ref_mult_en", {fwd_ref_sel, fwd_rate_mult, csi_bw_mult, sensor_clk_en}, mexp(c, mdl[5] & 1));
	endtask : mchk
	task automatic cnt(int n, output int t, output int r);
		logic so, rp;
		so = sensor_clk_out;
		rp = backch_ref_clk;
		t = 0;
		r = 0;
		repeat (n) begin
			@(posedge clk_sys);
			t += int'(sensor_clk_out !== so);
			r += int'(backch_ref_clk && !rp);
			so = sensor_clk_out;
			rp = backch_ref_clk;
		end
	endtask : cnt

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (100000) @(posedge clk_sys);
		mismatches++;
		$display("timeout");
		complete_run();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		int cs[5] = '{0, 2, 3, 5, 2};
		logic [7:0] ra[8] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h10, 8'h11, 8'h20};
		int t, r, e;
		logic tm, r12, pe;
		logic [5:0] dt, pd;
		logic [5:0] pick[4];
		seed = 32'h9727_402b;
		sys_rst = 1'b1;
		chip_power_enable = 1'b1;
		{mode_strap, reg_addr, reg_wdata, reg_we, reg_re, pkt_valid, pkt_dt} = '0;
		mdl[6] = 1;
		mdl[7] = 1;
		repeat (20) @(posedge clk_sys);
		sys_rst <= 1'b0;
		// The synchroniser gives a strap capture just after release
		repeat (6) @(posedge clk_sys);
		foreach (ra[i]) rd(ra[i], 8'hFF);
		wr(SCM_OFS_MODE, 8'h02, 8'h00);
		rd(SCM_OFS_MODE, 8'hFF);
		mchk(0);
		$display("test reset_and_readonly done");
		for (int i = 0; i < 5; i++) begin
			if (i == 4) wr(SCM_OFS_CLKCFG, 8'h01, 8'h09);
			wr(SCM_OFS_MODE, 8'(8'h10 | cs[i]), 8'h17);
			mchk(cs[i]);
			rd(SCM_OFS_MODE, 8'hFF);
			if (i == 4) chk("input_ref_divider", input_ref_divider, 1);
		end
		wr(SCM_OFS_MODE, 8'h11, 8'h00);
		mchk(2);
		wr(SCM_OFS_MODE, 8'h15, 8'h17);
		mchk(5);
		wr(SCM_OFS_CLKCFG, 8'h00, 8'h09);
		$display("test mode_select done");
		wr(SCM_OFS_MODE, 8'h10, 8'h17);
		wr(SCM_OFS_CLKOUT_N, 8'hA0, 8'hFF);
		for (int c = 0; c < 3; c++) begin
			wr(SCM_OFS_CLKOUT_M, 8'(8'h01 | (c << 5)), 8'h7F);
			rd(SCM_OFS_CLKOUT_M, 8'hFF);
			cnt(4000, t, r);
			e = r * 2 / (4 << c);
			chk("clk_out_toggles", (t >= e - 2 && t <= e + 2), 1);
		end
		wr(SCM_OFS_MODE, 8'h13, 8'h17);
		wr(SCM_OFS_CLKCFG, 8'h08, 8'h09);
		rd(SCM_OFS_CLKCFG, 8'hFF);
		chk("clkcfg_pins", {internal_osc_rate_select, input_ref_divider}, 2'b10);
		repeat (5) @(posedge clk_sys);
		cnt(1000, t, r);
		chk("clk_out_internal", t, 0);
		$display("test sensor_clock done");
		chip_power_enable <= 1'b0;
		mode_strap <= SCM_MODE_LEGACY;
		repeat (5) @(posedge clk_sys);
		chip_power_enable <= 1'b1;
		mdl[3] = 8'h15;
		repeat (8) @(posedge clk_sys);
		mchk(5);
		rd(SCM_OFS_MODE, 8'h07);
		$display("test strap_capture done");
		for (int k = 0; k < 32; k++) begin
			if (k % 8 == 0) begin
				tm = 1'($random(seed));
				r12 = 1'($random(seed));
				pd = 6'($random(seed));
				wr(SCM_OFS_PCFG, {tm, 7'h00}, 8'hFF);
				wr(SCM_OFS_FMT, {6'h00, r12, 1'b1}, 8'h03);
				wr(SCM_OFS_PDT, {2'h0, pd}, 8'h3F);
				rd(SCM_OFS_FMT, 8'hFF);
				chk("fmt_pins", {legacy_fmt_forced, legacy_fmt_raw12}, {1'b1, r12});
				chk("pcfg_pins", {type_match_enable, parallel_cfg}, {tm, tm, 7'h00});
			end
			pick = '{SCM_DT_RAW10, SCM_DT_RAW12, pd, 6'($random(seed))};
			dt = pick[$unsigned($random(seed)) % 4];
			pe = (tm && dt == pd) || dt == (r12 ? SCM_DT_RAW12 : SCM_DT_RAW10);
			@(posedge clk_sys);
			pkt_valid <= 1'b1;
			pkt_dt <= dt;
			@(posedge clk_sys);
			pkt_valid <= 1'b0;
			#1 chk("pkt_pass_vld", pkt_pass_vld, 1);
			chk("pkt_pass", pkt_pass, pe);
		end
		$display("test type_filter done");
		complete_run();
	end
endmodule : tb_top
